// ===== core/ladder_pkg.sv
// ladder_pkg: constants, field layout and carrier types for the reference ladder control
// assumes a 10 MHz core clock and an AXI4-Lite register slave with 32-bit data
package ladder_pkg;
   // register map, byte addresses
   localparam logic [3:0] CONTROL_OFFSET = 4'h0;   // reference_ladder_control
   localparam logic [3:0] STATUS_OFFSET  = 4'h4;   // effective ladder state, read only
   localparam logic [3:0] PORTDIR_OFFSET = 4'h8;   // port_f_direction shadow
   localparam logic [3:0] CMPMODE_OFFSET = 4'hC;   // comparator_mode_code
   localparam int         ADDR_W         = 4;      // decoded address bits

   // control register and port direction field positions
   localparam int POWER_BIT  = 7;                  // ladder_power_enable
   localparam int PINOE_BIT  = 6;                  // ladder_pin_output_enable
   localparam int RANGE_BIT  = 5;                  // ladder_range_select
   localparam int SOURCE_BIT = 4;                  // ladder_source_select
   localparam int CODE_MSB   = 3;                  // ladder_level_code top
   localparam int PIN5_BIT   = 5;                  // port f pin 5 direction bit

   localparam logic [7:0] CONTROL_RESET = 8'h00;   // every field clears
   localparam logic [7:0] PORTDIR_RESET = 8'hFE;   // pins come up as inputs
   localparam logic [2:0] CMPMODE_RESET = 3'h7;    // comparators off
   localparam logic [2:0] CMPMODE_LADDER = 3'h6;   // four inputs to two comparators

   // level arithmetic, numerator over a common denominator of 96
   localparam logic [7:0] LOW_STEP    = 8'h04;     // 96/24
   localparam logic [7:0] HIGH_STEP   = 8'h03;     // 96/32
   localparam logic [7:0] HIGH_OFFSET = 8'h18;     // 96/4
   localparam logic [7:0] LEVEL_DENOM = 8'h60;     // 96

   localparam logic [1:0] RESP_OKAY   = 2'h0;      // axi okay
   localparam logic [1:0] RESP_SLVERR = 2'h2;      // axi slave error

   // control register fields
   typedef struct packed {
      logic       powerEnable;
      logic       pinOutputEnable;
      logic       rangeSelect;
      logic       sourceSelect;
      logic [3:0] levelCode;
   } ladder_ctrl_t;

   // descriptor sent to the analog ladder and comparators
   typedef struct packed {
      logic       powerEnable;
      logic       lowRange;
      logic       externalSource;
      logic [3:0] levelCode;
      logic [7:0] levelNumerator;    // level = numerator/96 of the span
   } ladder_desc_t;
endpackage : ladder_pkg

// ===== core/ladder_level_calc.sv
// ladder_level_calc: works out the tap fraction of the source span
// assumes code and range come straight from the control register, same clock
`timescale 1ns/1ns
module ladder_level_calc (
   input  wire logic       rangeSelect,
   input  wire logic [3:0] levelCode,
   output logic      [7:0] levelNumerator
);
   // code*96/24 in the low range, 24 + code*96/32 in the high range
   always_comb begin
      if (rangeSelect) begin
         levelNumerator = 8'({4'h0, levelCode} * ladder_pkg::LOW_STEP);
      end else begin
         levelNumerator = 8'(ladder_pkg::HIGH_OFFSET
                          + {4'h0, levelCode} * ladder_pkg::HIGH_STEP);
      end
   end
endmodule : ladder_level_calc

// ===== core/ladder_pin_mux.sv
// ladder_pin_mux: decides who owns port f pin 5
// assumes the port direction bit is 1 for input, as on the rest of the port
`timescale 1ns/1ns
module ladder_pin_mux (
   input  wire logic pinOutputEnable,
   input  wire logic pin5DirInput,
   input  wire logic pin5Latch,
   output logic      analogRouteOn,
   output logic      digitalOut,
   output logic      digitalOe
);
   // the analog route wins over the direction bit, whatever it holds
   always_comb begin
      analogRouteOn = pinOutputEnable;
      digitalOe     = ~pinOutputEnable & ~pin5DirInput;
      digitalOut    = digitalOe & pin5Latch;
   end
endmodule : ladder_pin_mux

// ===== core/comparator_reference_ladder_ctrl.sv
// comparator_reference_ladder_ctrl: register slave and control of the reference ladder
// assumes one 10 MHz clock, synchronous reset, an AXI4-Lite master on the same clock
// assumes pin5Latch comes from port logic on this clock, so it is not synchronised
// limitation: one write and one read outstanding; a response blocks the next request
`timescale 1ns/1ns
module comparator_reference_ladder_ctrl (
   input  wire logic                      clock,
   input  wire logic                      rst,
   // axi4-lite write address
   input  wire logic [31:0]               s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   // write data
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // write response
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // read address
   input  wire logic [31:0]               s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   // read data
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // port f pin 5 digital side
   input  wire logic                      pin5Latch,
   output logic                           pin5Out,
   output logic                           pin5Oe,
   // analog side
   output ladder_pkg::ladder_desc_t       ladderDesc,
   output logic                           ladderPinRoute,
   output logic                           comparatorRefSelect
);
   // control, direction shadow, comparator mode and descriptor registers
   ladder_pkg::ladder_ctrl_t ctrl_reg,    ctrl_next;     // reference_ladder_control
   logic [7:0]               portDir_reg, portDir_next;  // port_f_direction
   logic [2:0]               cmpMode_reg, cmpMode_next;  // comparator_mode_code
   ladder_pkg::ladder_desc_t desc_reg,    desc_next;     // analog descriptor

   // write channel state
   logic                     awHeld_reg,  awHeld_next;   // address captured
   logic [3:0]               awAddr_reg,  awAddr_next;
   logic                     wHeld_reg,   wHeld_next;    // data captured
   logic [31:0]              wData_reg,   wData_next;
   logic [3:0]               wStrb_reg,   wStrb_next;
   logic                     bValid_reg,  bValid_next;
   logic [1:0]               bResp_reg,   bResp_next;
   // read channel state
   logic                     rValid_reg,  rValid_next;
   logic [31:0]              rData_reg,   rData_next;
   logic [1:0]               rResp_reg,   rResp_next;

   logic [7:0]               levelNumerator;             // from the calculator
   logic                     doWrite;                    // both halves present

   // one decode used by both channels
   function automatic logic addrMapped(input logic [3:0] a);
      addrMapped = (a == ladder_pkg::CONTROL_OFFSET) || (a == ladder_pkg::STATUS_OFFSET)
                || (a == ladder_pkg::PORTDIR_OFFSET) || (a == ladder_pkg::CMPMODE_OFFSET);
   endfunction : addrMapped

   ladder_level_calc u_calc (
      .rangeSelect    (ctrl_reg.rangeSelect),
      .levelCode      (ctrl_reg.levelCode),
      .levelNumerator (levelNumerator)
   );

   ladder_pin_mux u_pin (
      .pinOutputEnable (ctrl_reg.pinOutputEnable),
      .pin5DirInput    (portDir_reg[ladder_pkg::PIN5_BIT]),
      .pin5Latch       (pin5Latch),
      .analogRouteOn   (ladderPinRoute),
      .digitalOut      (pin5Out),
      .digitalOe       (pin5Oe)
   );

   // ready only while the slot is empty and no response waits
   assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
   assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;
   assign s_axi_arready = ~rValid_reg;
   assign doWrite       = awHeld_reg & wHeld_reg & ~bValid_reg;

   // write path; address and data may arrive in either order
   // the pending response keeps both readies low, so a half cannot be taken twice
   always_comb begin
      awHeld_next  = awHeld_reg;
      awAddr_next  = awAddr_reg;
      wHeld_next   = wHeld_reg;
      wData_next   = wData_reg;
      wStrb_next   = wStrb_reg;
      bValid_next  = bValid_reg;
      bResp_next   = bResp_reg;
      ctrl_next    = ctrl_reg;     // holds through sleep, only reset or write changes it
      portDir_next = portDir_reg;
      cmpMode_next = cmpMode_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         awHeld_next = 1'b1;
         awAddr_next = s_axi_awaddr[ladder_pkg::ADDR_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeld_next = 1'b1;
         wData_next = s_axi_wdata;
         wStrb_next = s_axi_wstrb;
      end
      if (doWrite) begin
         awHeld_next = 1'b0;
         wHeld_next  = 1'b0;
         bValid_next = 1'b1;
         bResp_next  = addrMapped(awAddr_reg) ? ladder_pkg::RESP_OKAY
                                              : ladder_pkg::RESP_SLVERR;
         // only the low byte lane carries data
         if (wStrb_reg[0]) begin
            case (awAddr_reg)
               ladder_pkg::CONTROL_OFFSET: begin
                  ctrl_next = ladder_pkg::ladder_ctrl_t'(wData_reg[7:0]);
               end
               ladder_pkg::PORTDIR_OFFSET: begin
                  portDir_next = {wData_reg[7:1], 1'b0};   // bit 0 unimplemented
               end
               ladder_pkg::CMPMODE_OFFSET: begin
                  cmpMode_next = wData_reg[2:0];
               end
               default: begin
                  ctrl_next = ctrl_reg;                    // status and unmapped ignore data
               end
            endcase
         end
      end
      if (bValid_reg && s_axi_bready) begin
         bValid_next = 1'b0;
      end
   end

   // read path, one cycle from address to data
   // arready stays low while rvalid waits, so read data cannot be overwritten
   always_comb begin
      rValid_next = rValid_reg;
      rData_next  = rData_reg;
      rResp_next  = rResp_reg;
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_next = 1'b1;
         rResp_next  = addrMapped(s_axi_araddr[ladder_pkg::ADDR_W-1:0])
                       ? ladder_pkg::RESP_OKAY : ladder_pkg::RESP_SLVERR;
         case (s_axi_araddr[ladder_pkg::ADDR_W-1:0])
            ladder_pkg::CONTROL_OFFSET: rData_next = {24'h000000, ctrl_reg};
            ladder_pkg::STATUS_OFFSET:  rData_next = {16'h0000, desc_reg[7:0],
                                                      desc_reg.powerEnable,
                                                      ladderPinRoute,
                                                      comparatorRefSelect,
                                                      pin5Oe, 4'h0};
            ladder_pkg::PORTDIR_OFFSET: rData_next = {24'h000000, portDir_reg};
            ladder_pkg::CMPMODE_OFFSET: rData_next = {29'h00000000, cmpMode_reg};
            default:                    rData_next = 32'h00000000;
         endcase
      end else if (rValid_reg && s_axi_rready) begin
         rValid_next = 1'b0;
      end
   end

   // descriptor follows the control register one edge later, independent of mode
   // the one-edge lag keeps bus decode glitches away from the analog side
   always_comb begin
      desc_next.powerEnable    = ctrl_reg.powerEnable;
      desc_next.lowRange       = ctrl_reg.rangeSelect;
      desc_next.externalSource = ctrl_reg.sourceSelect;
      desc_next.levelCode      = ctrl_reg.levelCode;
      desc_next.levelNumerator = levelNumerator;
   end

   // registers; reset clears the control fields
   // sync reset: every register, bus state included, returns to its idle value
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_reg    <= ladder_pkg::ladder_ctrl_t'(ladder_pkg::CONTROL_RESET);
         portDir_reg <= ladder_pkg::PORTDIR_RESET;
         cmpMode_reg <= ladder_pkg::CMPMODE_RESET;
         // cleared control means high range, code 0: the descriptor starts on that tap
         desc_reg    <= ladder_pkg::ladder_desc_t'({7'h00, ladder_pkg::HIGH_OFFSET});
         awHeld_reg  <= 1'b0;
         awAddr_reg  <= 4'h0;
         wHeld_reg   <= 1'b0;
         wData_reg   <= 32'h00000000;
         wStrb_reg   <= 4'h0;
         bValid_reg  <= 1'b0;
         bResp_reg   <= ladder_pkg::RESP_OKAY;
         rValid_reg  <= 1'b0;
         rData_reg   <= 32'h00000000;
         rResp_reg   <= ladder_pkg::RESP_OKAY;
      end else begin
         ctrl_reg    <= ctrl_next;
         portDir_reg <= portDir_next;
         cmpMode_reg <= cmpMode_next;
         desc_reg    <= desc_next;
         awHeld_reg  <= awHeld_next;
         awAddr_reg  <= awAddr_next;
         wHeld_reg   <= wHeld_next;
         wData_reg   <= wData_next;
         wStrb_reg   <= wStrb_next;
         bValid_reg  <= bValid_next;
         bResp_reg   <= bResp_next;
         rValid_reg  <= rValid_next;
         rData_reg   <= rData_next;
         rResp_reg   <= rResp_next;
      end
   end

   // comparators take the ladder only in the shared four-input mode
   assign comparatorRefSelect = desc_reg.powerEnable
                              & (cmpMode_reg == ladder_pkg::CMPMODE_LADDER);
   assign ladderDesc   = desc_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp  = bResp_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata  = rData_reg;
   assign s_axi_rresp  = rResp_reg;

   // assertions next to the logic they guard
   // descriptor fields trail the control fields by exactly one edge
   a_power_follows: assert property (@(posedge clock) disable iff (rst)
      ladderDesc.powerEnable == $past(ctrl_reg.powerEnable))
      else $error("ladder power does not follow enable bit");
   a_range_follows: assert property (@(posedge clock) disable iff (rst)
      ladderDesc.lowRange == $past(ctrl_reg.rangeSelect))
      else $error("range select not passed on");
   a_source_sel: assert property (@(posedge clock) disable iff (rst)
      ladderDesc.externalSource == $past(ctrl_reg.sourceSelect))
      else $error("source select not passed on");
   a_code_follows: assert property (@(posedge clock) disable iff (rst)
      ladderDesc.levelCode == $past(ctrl_reg.levelCode))
      else $error("level code not passed on");
   // pin ownership: the ladder route beats the direction bit
   a_pin_route: assert property (@(posedge clock) disable iff (rst)
      ladderPinRoute == ctrl_reg.pinOutputEnable)
      else $error("pin route does not follow output enable");
   a_pin_override: assert property (@(posedge clock) disable iff (rst)
      ctrl_reg.pinOutputEnable |-> !pin5Oe)
      else $error("digital driver active while ladder owns pin");
   a_pin_drive: assert property (@(posedge clock) disable iff (rst)
      !ctrl_reg.pinOutputEnable && !portDir_reg[ladder_pkg::PIN5_BIT] |-> pin5Oe)
      else $error("digital driver off although pin is a free output");
   // tap arithmetic, numerator over 96 of the span
   a_low_level: assert property (@(posedge clock) disable iff (rst)
      $past(ctrl_reg.rangeSelect) |->
      ladderDesc.levelNumerator == 8'({4'h0, ladderDesc.levelCode} * ladder_pkg::LOW_STEP))
      else $error("low range level wrong");
   a_high_level: assert property (@(posedge clock) disable iff (rst)
      !ladderDesc.lowRange |-> ladderDesc.levelNumerator == 8'(ladder_pkg::HIGH_OFFSET
         + {4'h0, ladderDesc.levelCode} * ladder_pkg::HIGH_STEP))
      else $error("high range level wrong");
   a_level_bound: assert property (@(posedge clock) disable iff (rst)
      ladderDesc.levelNumerator <= 8'(ladder_pkg::HIGH_OFFSET + 8'h0F * ladder_pkg::HIGH_STEP))
      else $error("level beyond top tap");
   // reset and hold: only a reset or a control write moves the register
   a_reset_clear: assert property (@(posedge clock)
      $past(rst) |-> ctrl_reg == ladder_pkg::CONTROL_RESET)
      else $error("control not cleared by reset");
   a_hold_nowrite: assert property (@(posedge clock) disable iff (rst)
      !$past(doWrite) && !$past(rst) |-> $stable(ctrl_reg))
      else $error("control changed without a write");
   a_other_write: assert property (@(posedge clock) disable iff (rst)
      doWrite && awAddr_reg != ladder_pkg::CONTROL_OFFSET |=> $stable(ctrl_reg))
      else $error("control changed by a write elsewhere");
   // write landing: control one edge after the write, descriptor one more
   a_write_ctrl: assert property (@(posedge clock) disable iff (rst)
      doWrite && awAddr_reg == ladder_pkg::CONTROL_OFFSET && wStrb_reg[0] |=>
      ctrl_reg == $past(wData_reg[7:0]))
      else $error("control write did not land");
   a_write_to_desc: assert property (@(posedge clock) disable iff (rst)
      doWrite && awAddr_reg == ladder_pkg::CONTROL_OFFSET && wStrb_reg[0] |->
      ##2 ladderDesc.levelCode == $past(wData_reg[3:0], 2))
      else $error("descriptor not updated two edges after write");
   // comparator hand-off; the pin route ignores the comparator mode
   a_cmp_ref: assert property (@(posedge clock) disable iff (rst)
      comparatorRefSelect |-> cmpMode_reg == ladder_pkg::CMPMODE_LADDER)
      else $error("comparator reference outside mode 110");
   a_cmp_ref_on: assert property (@(posedge clock) disable iff (rst)
      ladderDesc.powerEnable && cmpMode_reg == ladder_pkg::CMPMODE_LADDER |-> comparatorRefSelect)
      else $error("comparator reference missing in mode 110");
   a_indep_mode: assert property (@(posedge clock) disable iff (rst)
      ctrl_reg.pinOutputEnable && cmpMode_reg != ladder_pkg::CMPMODE_LADDER |-> ladderPinRoute)
      else $error("pin route depends on comparator mode");
endmodule : comparator_reference_ladder_ctrl

// ===== verif/comparator_reference_ladder_ctrl_test.sv
// comparator_reference_ladder_ctrl_test: self-checking bench for the reference ladder control
// assumes ladder_pkg is compiled first and the block is the only axi4-lite slave on one clock
`timescale 1ns/1ns
module comparator_reference_ladder_ctrl_test;
   logic                    clock;        // 10 MHz core clock
   logic                    rst;          // sync reset, active high
   logic [31:0]             awAddr;       // write channel payloads
   logic [31:0]             wData;
   logic [3:0]              wStrb;
   logic                    awValid;
   logic                    awReady;
   logic                    wValid;
   logic                    wReady;
   logic [1:0]              bResp;
   logic                    bValid;
   logic                    bReady;
   logic [31:0]             arAddr;       // read channel payloads
   logic                    arValid;
   logic                    arReady;
   logic [31:0]             rData;
   logic [1:0]              rResp;
   logic                    rValid;
   logic                    rReady;
   logic                    pin5Latch;    // port latch fed to the pin mux
   logic                    pin5Out;
   logic                    pin5Oe;
   ladder_pkg::ladder_desc_t ladderDesc;
   logic                    ladderPinRoute;
   logic                    comparatorRefSelect;
   int                      miscompares;  // mismatches seen
   int                      n_checks;     // comparisons made
   logic [1:0]              resp;         // last bus response
   logic [31:0]             val;          // last read word

   comparator_reference_ladder_ctrl dut (.clock(clock), .rst(rst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .pin5Latch(pin5Latch), .pin5Out(pin5Out), .pin5Oe(pin5Oe), .ladderDesc(ladderDesc),
      .ladderPinRoute(ladderPinRoute), .comparatorRefSelect(comparatorRefSelect));

   // free-running clock, 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // verdict and end of run, also reached from any timeout
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   // one comparison, four-state exact
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // bounded wait guard shared by both bus tasks
   task automatic tick_guard(inout int n);
      n++;
      if (n > 40) begin
         miscompares++;
         complete_run();
      end
   endtask : tick_guard

   // axi4-lite write: address and data offered together, each dropped once taken
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clock);
      awAddr  <= {28'h0000000, a};
      wData   <= d;
      wStrb   <= s;
      awValid <= 1'b1;
      wValid  <= 1'b1;
      bReady  <= 1'b1;
      forever begin
         @(posedge clock);
         if (awValid && awReady) awValid <= 1'b0;
         if (wValid && wReady) wValid <= 1'b0;
         if (bValid) break;   // response taken at this edge
         tick_guard(n);
      end
      r = bResp;
      bReady <= 1'b0;
   endtask : axi_write

   // axi4-lite read, rready held until rvalid is sampled
   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clock);
      arAddr  <= {28'h0000000, a};
      arValid <= 1'b1;
      rReady  <= 1'b1;
      forever begin
         @(posedge clock);
         if (arValid && arReady) arValid <= 1'b0;
         if (rValid) break;
         tick_guard(n);
      end
      d = rData;
      r = rResp;
      rReady <= 1'b0;
   endtask : axi_read

   // tap numerator over 96: low range code*4, high range 24 + code*3
   function automatic logic [7:0] exp_num(input logic [7:0] c);
      return c[5] ? {4'h0, c[3:0]} * 8'h04 : 8'h18 + {4'h0, c[3:0]} * 8'h03;
   endfunction : exp_num

   // program control, direction and mode, then check every visible effect
   task automatic set_and_check(input logic [7:0] c, input logic [7:0] d, input logic [2:0] m);
      logic oe;
      logic cref;
      oe   = ~c[6] & ~d[5];
      cref = c[7] & (m == 3'h6);
      pin5Latch <= 1'($urandom);
      axi_write(4'h8, {24'h0, d}, 4'hF, resp);
      axi_write(4'hC, {29'h0, m}, 4'hF, resp);
      axi_write(4'h0, {24'h0, c}, 4'hF, resp);
      check("write resp", 32'(ladder_pkg::RESP_OKAY), 32'(resp));
      axi_read(4'h0, val, resp);
      check("control", {24'h0, c}, val);
      #1;
      check("descriptor", {17'h0, c[7], c[5], c[4], c[3:0], exp_num(c)}, 32'(ladderDesc));
      check("pin route", 32'(c[6]), 32'(ladderPinRoute));
      check("pin drive", 32'(oe), 32'(pin5Oe));
      check("pin out", 32'(oe & pin5Latch), 32'(pin5Out));
      check("comparator ref", 32'(cref), 32'(comparatorRefSelect));
      axi_read(4'h4, val, resp);
      check("status", {16'h0, exp_num(c), c[7], c[6], cref, oe, 4'h0}, val);
   endtask : set_and_check

   // reset, then read control and status back against their reset values and check the descriptor
   task automatic reset_and_check();
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      axi_read(4'h0, val, resp);
      check("control reset", 32'h00000000, val);
      axi_read(4'h4, val, resp);
      check("status reset", {16'h0, exp_num(8'h00), 8'h00}, val);
      check("desc reset", {24'h0, exp_num(8'h00)}, 32'(ladderDesc));
   endtask : reset_and_check

   // main sequence
   initial begin
      logic [7:0] corner [6];
      rst = 1'b1;
      awAddr = 32'h0; wData = 32'h0; wStrb = 4'h0; awValid = 1'b0; wValid = 1'b0;
      bReady = 1'b0; arAddr = 32'h0; arValid = 1'b0; rReady = 1'b0; pin5Latch = 1'b0;
      miscompares = 0;
      n_checks = 0;
      corner = '{8'hFF, 8'h00, 8'hEF, 8'hDF, 8'hC0, 8'h6A};
      void'($urandom(32'h2419F834));
      reset_and_check();
      axi_read(4'h8, val, resp);
      check("direction reset", 32'h000000FE, val);
      axi_read(4'hC, val, resp);
      check("mode reset", 32'h00000007, val);
      // corner values with pin 5 set as an output so the override shows
      foreach (corner[i]) set_and_check(corner[i], 8'hDE, 3'h6);
      // every comparator mode with the ladder powered
      for (int m = 0; m < 8; m++) set_and_check(8'h80 | 8'($urandom), 8'hDE, 3'(m));
      // random traffic, both ranges and both sources
      repeat (20) set_and_check(8'($urandom), 8'($urandom) & 8'hFE, 3'($urandom));
      set_and_check(8'h9F, 8'hFE, 3'h6);
      // unmapped place: error response, nothing changes
      axi_write(4'h2, 32'h000000FF, 4'hF, resp);
      check("unmapped wresp", 32'(ladder_pkg::RESP_SLVERR), 32'(resp));
      axi_read(4'h2, val, resp);
      check("unmapped rresp", 32'(ladder_pkg::RESP_SLVERR), 32'(resp));
      check("unmapped data", 32'h00000000, val);
      // masked byte and read-only status writes leave control alone
      axi_write(4'h0, 32'h00000055, 4'h0, resp);
      axi_write(4'h4, 32'h0000FFFF, 4'hF, resp);
      check("status wresp", 32'(ladder_pkg::RESP_OKAY), 32'(resp));
      // idle stretch stands in for sleep: contents must hold
      repeat (50) @(posedge clock);
      axi_read(4'h0, val, resp);
      check("control held", 32'h0000009F, val);
      // second reset in mid-run
      reset_and_check();
      complete_run();
   end
endmodule : comparator_reference_ladder_ctrl_test
